/* src/mcbi_top.sv */
// Modem command block interpreter with AHB-Lite shared word memory

//
// Function
// RULE1 - Command 1 opens a connection and starts the handler on the chosen port
// RULE2 - Option bit 0 set reads the modem configuration table at word 11's address
// RULE3 - Host assigns an unused connection number from 19221 to 19299
// RULE4 - Handler selector 36 peer transfer, 38 generic ascii, 32 task code
// RULE5 - Port selector names serial port 1 to 4
// RULE6 - Line speed is one of seven rates; port runs at that rate
// RULE7 - Data bits 7 or 8, parity 0 none 1 odd 2 even, stop 1 or 2
// RULE8 - Host sets 7 data bits, odd parity, 1 stop for peer and task handlers
// RULE9 - Flow control 0 none, 1 software, 2 hardware
// RULE10 - Host zeroes word 0; device writes an error code there on failure
// RULE11 - Command 0x0401 takes the modem off hook and dials
// RULE12 - Host gives the dial block the number used at open
// RULE13 - Flag bit 0 clear resets modem and loads defaults first; set skips it
// RULE14 - Dial text address of zero is invalid
// RULE15 - Busy and dial tone detection each 0 enabled, 1 disabled
// RULE16 - With tone detection off, wait-for-tone modifiers become timed pauses
// RULE17 - After dial, mode word 0 leaves data mode, 1 leaves command mode
// RULE18 - Dial ends on modem completion, bounded by timeout; no link gives error
// RULE19 - Command 0x0402 ends the connection and puts the modem on hook
// RULE20 - After hang-up, auto answer is enabled when the table asks for it
// RULE21 - Hang-up while already on hook completes without error
// RULE22 - Host should hang up after an aborted manual dial
// RULE23 - With auto dial, a data command without a link dials first
// RULE24 - Configuration table word 0 must hold signature 0x4154
// RULE25 - Dial or hang-up with unknown connection number gets an error code
module mcbi_top import mcbi_pkg::*; #(
   parameter int MEM_AW     = 6,
   parameter int SEC_CYC    = SEC_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        modem_dial_done,
   input  wire logic        modem_dial_ok,
   output logic      [3:0]  modem_txd,
   output logic             modem_reset,
   output logic             modem_off_hook,
   output logic             modem_data_mode,
   output logic             modem_auto_answer,
   output logic             modem_busy_det_off,
   output logic             modem_tone_det_off,
   output logic             handler_run,
   output logic      [5:0]  handler_sel,
   output logic      [1:0]  port_sel,
   output logic      [1:0]  flow_sel
);
   localparam int WORDS = 1 << MEM_AW;

   logic [15:0]       mem_r [WORDS];
   logic              wr_pend_r;
   logic [11:0]       wr_addr_r;
   mcbi_state_t       state_r;
   logic [MEM_AW-1:0] base_r;
   logic [15:0]       err_r;
   logic [15:0]       blk [16];
   logic [15:0]       cfg [8];
   logic              doorbell_wr;
   logic              conn_open_r;
   logic [15:0]       conn_id_r;
   logic              modem_en_r;
   logic              eight_r;
   logic [1:0]        par_r;
   logic              two_stop_r;
   logic [16:0]       baud_div_r;
   logic              autodial_r;
   logic              rings_on_r;
   logic [MEM_AW-1:0] cfg_str_r;
   logic [15:0]       cfg_tmo_r;
   logic              cfg_busy_off_r;
   logic              cfg_tone_off_r;
   logic              connected_r;
   logic              cmd_mode_r;
   logic              skip_reset_r;
   logic [MEM_AW-1:0] str_ptr_r;
   logic              byte_lo_r;
   logic [5:0]        ch_cnt_r;
   logic [15:0]       tmo_r;
   logic              tx_start_r;
   logic [7:0]        tx_data_r;
   logic              tx_busy;
   logic              tx_line;
   logic              baud_en;
   logic              sec_en;
   logic [7:0]        ch;
   logic [16:0]       div_for;
   logic              open_ok;
   logic [15:0]       open_err;
   logic              conn_match;

   // ======================================================
   // Block and table views
   for (genvar i = 0; i < 16; i++) begin : g_blk
      assign blk[i] = mem_r[base_r + MEM_AW'(i)];
   end
   for (genvar i = 0; i < 8; i++) begin : g_cfg
      assign cfg[i] = mem_r[MEM_AW'(blk[OFF_CFGADDR]) + MEM_AW'(i)];
   end

   assign doorbell_wr = wr_pend_r && (wr_addr_r == ADDR_DOORBELL);
   assign conn_match  = conn_open_r && (blk[OFF_CONN] == conn_id_r);
   assign ch          = byte_lo_r ? mem_r[str_ptr_r][7:0] : mem_r[str_ptr_r][15:8];

   // ======================================================
   // AHB-Lite slave, zero wait states
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 12'h000;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wr_pend_r <= 1'b0;
         if (hsel && htrans[1] && hready) begin
            wr_pend_r <= hwrite;
            wr_addr_r <= haddr[11:0];
            hrdata    <= 32'h0000_0000;
            if (!hwrite) begin
               if (haddr[11:8] == 4'h0 && 32'(haddr[7:2]) < WORDS) begin
                  hrdata <= {16'h0000, mem_r[haddr[MEM_AW+1:2]]};
               end else if (haddr[11:0] == ADDR_STATUS) begin
                  hrdata <= {24'h000000, cmd_mode_r, autodial_r, modem_en_r,
                             conn_open_r, connected_r, modem_off_hook,
                             modem_data_mode, state_r != ST_IDLE};
               end
            end
         end
      end
   end

   // ======================================================
   // Shared memory; the interpreter's error write wins a collision
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < WORDS; i++) begin
            mem_r[i] <= 16'h0000;
         end
      end else if (state_r == ST_FINISH && err_r != ERR_NONE) begin
         mem_r[base_r] <= err_r; // [RULE10]
      end else if (wr_pend_r && wr_addr_r[11:8] == 4'h0
                   && 32'(wr_addr_r[7:2]) < WORDS) begin
         mem_r[wr_addr_r[MEM_AW+1:2]] <= hwdata[15:0];
      end
   end

   // ======================================================
   // Open-block checks
   always_comb begin
      case (blk[OFF_BAUD]) // [RULE6]
         16'd300, 16'd600, 16'd1200, 16'd2400,
         16'd4800, 16'd9600, 16'd19200: div_for = 17'(CLK_HZ / int'(blk[OFF_BAUD]));
         default: div_for = 17'd0;
      endcase
      open_err = ERR_NONE;
      if (blk[OFF_CONN] < CONN_MIN || blk[OFF_CONN] > CONN_MAX) begin
         open_err = ERR_CONN;
      end else if (blk[OFF_HANDLER] != HND_PEER && blk[OFF_HANDLER] != HND_ASCII
                   && blk[OFF_HANDLER] != HND_TASK) begin // [RULE4]
         open_err = ERR_PARAM;
      end else if (blk[OFF_PORT] < 16'd1 || blk[OFF_PORT] > 16'd4) begin // [RULE5]
         open_err = ERR_PARAM;
      end else if (div_for == 17'd0) begin
         open_err = ERR_PARAM;
      end else if ((blk[OFF_BITS] != 16'd7 && blk[OFF_BITS] != 16'd8)
                   || blk[OFF_PARITY] > 16'd2
                   || (blk[OFF_STOP] != 16'd1 && blk[OFF_STOP] != 16'd2)) begin // [RULE7]
         open_err = ERR_PARAM;
      end else if (blk[OFF_FLOW] > 16'd2) begin // [RULE9]
         open_err = ERR_PARAM;
      end else if (blk[OFF_OPTION][0]) begin // [RULE2]
         if (blk[OFF_CFGADDR] > 16'(WORDS - 8)) begin
            open_err = ERR_ADDR;
         end else if (cfg[0] != CFG_SIGNATURE) begin // [RULE24]
            open_err = ERR_SIG;
         end
      end
      open_ok = (open_err == ERR_NONE);
   end

   // ======================================================
   // Connection record, latched on a good open
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         conn_open_r    <= 1'b0;
         conn_id_r      <= 16'h0000;
         modem_en_r     <= 1'b0;
         handler_run    <= 1'b0;
         handler_sel    <= 6'h00;
         port_sel       <= 2'd0;
         flow_sel       <= 2'd0;
         eight_r        <= 1'b0;
         par_r          <= 2'd0;
         two_stop_r     <= 1'b0;
         baud_div_r     <= 17'h1ffff;
         autodial_r     <= 1'b0;
         rings_on_r     <= 1'b0;
         cfg_str_r      <= '0;
         cfg_tmo_r      <= 16'h0000;
         cfg_busy_off_r <= 1'b0;
         cfg_tone_off_r <= 1'b0;
      end else if (state_r == ST_DECODE && blk[OFF_CMD] == CMD_OPEN && open_ok) begin
         conn_open_r <= 1'b1; // [RULE1]
         conn_id_r   <= blk[OFF_CONN];
         handler_run <= 1'b1;
         handler_sel <= blk[OFF_HANDLER][5:0]; // [RULE4]
         port_sel    <= 2'(blk[OFF_PORT] - 16'd1); // [RULE5]
         baud_div_r  <= div_for; // [RULE6]
         eight_r     <= blk[OFF_BITS] == 16'd8; // [RULE7]
         par_r       <= blk[OFF_PARITY][1:0];
         two_stop_r  <= blk[OFF_STOP] == 16'd2;
         flow_sel    <= blk[OFF_FLOW][1:0]; // [RULE9]
         modem_en_r  <= blk[OFF_OPTION][0];
         if (blk[OFF_OPTION][0]) begin // [RULE2]
            rings_on_r     <= cfg[CFG_RINGS] != 16'h0000;
            autodial_r     <= cfg[CFG_AUTODIAL][0];
            cfg_busy_off_r <= cfg[CFG_FLAGS][CFG_BUSY_BIT];
            cfg_tone_off_r <= cfg[CFG_FLAGS][CFG_TONE_BIT];
            cfg_str_r      <= MEM_AW'(cfg[CFG_DSTR]);
            cfg_tmo_r      <= (cfg[CFG_DTMO] == 16'h0000) ? DEF_DIAL_TMO_S : cfg[CFG_DTMO];
         end else begin
            autodial_r <= 1'b0;
            rings_on_r <= 1'b0;
         end
      end
   end

   // ======================================================
   // Interpreter sequence
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r            <= ST_IDLE;
         base_r             <= '0;
         err_r              <= ERR_NONE;
         connected_r        <= 1'b0;
         cmd_mode_r         <= 1'b0;
         skip_reset_r       <= 1'b0;
         str_ptr_r          <= '0;
         byte_lo_r          <= 1'b0;
         ch_cnt_r           <= 6'd0;
         tmo_r              <= 16'h0000;
         tx_start_r         <= 1'b0;
         tx_data_r          <= 8'h00;
         modem_reset        <= 1'b0;
         modem_off_hook     <= 1'b0;
         modem_data_mode    <= 1'b0;
         modem_auto_answer  <= 1'b0;
         modem_busy_det_off <= 1'b0;
         modem_tone_det_off <= 1'b0;
      end else begin
         tx_start_r  <= 1'b0;
         modem_reset <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (doorbell_wr && hwdata[15:0] < 16'(WORDS)) begin
                  base_r  <= MEM_AW'(hwdata[15:0]);
                  err_r   <= ERR_NONE;
                  state_r <= ST_DECODE;
               end
            end
            ST_DECODE: begin
               state_r <= ST_FINISH;
               if (blk[OFF_CMD] == CMD_OPEN) begin
                  err_r <= open_err;
               end else if (blk[OFF_CMD] == CMD_DIAL) begin // [RULE11]
                  if (!conn_match || !modem_en_r) begin
                     err_r <= ERR_CONN; // [RULE25]
                  end else if (blk[OFF_DSTR] == 16'h0000
                               || blk[OFF_DSTR] >= 16'(WORDS)) begin
                     err_r <= ERR_ADDR; // [RULE14]
                  end else begin
                     skip_reset_r       <= blk[OFF_DFLAG][0]; // [RULE13]
                     str_ptr_r          <= MEM_AW'(blk[OFF_DSTR]);
                     modem_busy_det_off <= blk[OFF_DBUSY][0]; // [RULE15]
                     modem_tone_det_off <= blk[OFF_DTONE][0];
                     cmd_mode_r         <= blk[OFF_DMODE][0]; // [RULE17]
                     tmo_r              <= (blk[OFF_DTMO] == 16'h0000) ? DEF_DIAL_TMO_S
                                                                     : blk[OFF_DTMO];
                     byte_lo_r          <= 1'b0;
                     ch_cnt_r           <= 6'd0;
                     state_r            <= ST_RESET;
                  end
               end else if (blk[OFF_CMD] == CMD_HANGUP) begin // [RULE19]
                  if (!conn_match) begin
                     err_r <= ERR_CONN; // [RULE25]
                  end else begin
                     // Already on hook is harmless and reports nothing
                     modem_off_hook    <= 1'b0; // [RULE21]
                     connected_r       <= 1'b0;
                     modem_data_mode   <= 1'b0;
                     modem_auto_answer <= modem_en_r && rings_on_r; // [RULE20]
                  end
               end else if (!conn_match) begin
                  err_r <= ERR_CMD;
               end else if (modem_en_r && autodial_r && !connected_r) begin // [RULE23]
                  skip_reset_r       <= 1'b0;
                  str_ptr_r          <= cfg_str_r;
                  modem_busy_det_off <= cfg_busy_off_r;
                  modem_tone_det_off <= cfg_tone_off_r;
                  cmd_mode_r         <= 1'b0;
                  tmo_r              <= cfg_tmo_r;
                  byte_lo_r          <= 1'b0;
                  ch_cnt_r           <= 6'd0;
                  state_r            <= ST_RESET;
               end
            end
            ST_RESET: begin
               modem_reset       <= !skip_reset_r; // [RULE13]
               modem_off_hook    <= 1'b1; // [RULE11]
               modem_auto_answer <= 1'b0;
               state_r           <= ST_SEND;
            end
            ST_SEND: begin
               if (!tx_busy && !tx_start_r) begin
                  if (ch == 8'h00 || ch_cnt_r == 6'(DSTR_MAX_CH)) begin
                     state_r <= ST_WAIT;
                  end else begin
                     if (ch != CH_QUOTE) begin
                        tx_start_r <= 1'b1;
                        // A tone wait would hang forever with detection off
                        tx_data_r  <= (modem_tone_det_off && (ch == CH_WAIT_UP
                                       || ch == CH_WAIT_LO)) ? CH_PAUSE : ch; // [RULE16]
                     end
                     ch_cnt_r  <= ch_cnt_r + 6'd1;
                     byte_lo_r <= !byte_lo_r;
                     if (byte_lo_r) begin
                        str_ptr_r <= str_ptr_r + MEM_AW'(1);
                     end
                  end
               end
            end
            ST_WAIT: begin
               if (modem_dial_done) begin // [RULE18]
                  state_r <= ST_FINISH;
                  if (modem_dial_ok) begin
                     connected_r     <= 1'b1;
                     modem_data_mode <= !cmd_mode_r; // [RULE17]
                  end else begin
                     err_r <= ERR_NOLINK;
                  end
               end else if (sec_en) begin
                  tmo_r <= tmo_r - 16'd1;
                  if (tmo_r <= 16'd1) begin
                     err_r   <= ERR_TIMEOUT; // [RULE18]
                     state_r <= ST_FINISH;
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ======================================================
   // Serial line and rate enables
   mcbi_divider #(.W(17)) u_baud (
      .clk  (clk),
      .rst  (rst),
      .div  (baud_div_r),
      .tick (baud_en)
   );

   mcbi_divider #(.W(25)) u_sec (
      .clk  (clk),
      .rst  (rst),
      .div  (25'(SEC_CYC)),
      .tick (sec_en)
   );

   mcbi_uart_tx u_tx (
      .clk        (clk),
      .rst        (rst),
      .baud_en    (baud_en),
      .start      (tx_start_r),
      .data       (tx_data_r),
      .eight_bits (eight_r),
      .parity     (par_r),
      .two_stop   (two_stop_r),
      .txd        (tx_line),
      .busy       (tx_busy)
   );

   // Only the selected port carries characters; the others idle at mark
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         modem_txd <= 4'hf;
      end else begin
         for (int p = 0; p < 4; p++) begin
            modem_txd[p] <= (port_sel == 2'(p)) ? tx_line : 1'b1; // [RULE5]
         end
      end
   end
endmodule

/* src/mcbi_pkg.sv */
// Constants shared by the modem command block interpreter
package mcbi_pkg;
   // ======================================================
   // Command block layout and codes
   localparam logic [15:0] CMD_OPEN     = 16'h0001;
   localparam logic [15:0] CMD_DIAL     = 16'h0401;
   localparam logic [15:0] CMD_HANGUP   = 16'h0402;
   localparam logic [15:0] CONN_MIN     = 16'd19221;
   localparam logic [15:0] CONN_MAX     = 16'd19299;
   localparam logic [15:0] HND_PEER     = 16'd36;
   localparam logic [15:0] HND_ASCII    = 16'd38;
   localparam logic [15:0] HND_TASK     = 16'd32;
   localparam logic [15:0] CFG_SIGNATURE = 16'h4154;
   localparam int          OFF_CMD      = 1;
   localparam int          OFF_CONN     = 2;
   localparam int          OFF_HANDLER  = 3;
   localparam int          OFF_PORT     = 4;
   localparam int          OFF_BAUD     = 5;
   localparam int          OFF_BITS     = 6;
   localparam int          OFF_PARITY   = 7;
   localparam int          OFF_STOP     = 8;
   localparam int          OFF_FLOW     = 9;
   localparam int          OFF_OPTION   = 10;
   localparam int          OFF_CFGADDR  = 11;
   localparam int          OFF_DFLAG    = 3;
   localparam int          OFF_DSTR     = 4;
   localparam int          OFF_DBUSY    = 5;
   localparam int          OFF_DTONE    = 6;
   localparam int          OFF_DMODE    = 7;
   localparam int          OFF_DTMO     = 8;
   // Configuration table offsets; flag bit positions count the least significant bit as bit 0
   localparam int          CFG_RINGS    = 2;
   localparam int          CFG_AUTODIAL = 3;
   localparam int          CFG_FLAGS    = 4;
   localparam int          CFG_DSTR     = 6;
   localparam int          CFG_DTMO     = 7;
   localparam int          CFG_BUSY_BIT = 2;
   localparam int          CFG_TONE_BIT = 1;
   localparam logic [15:0] DEF_DIAL_TMO_S = 16'd30;
   // ======================================================
   // Error codes written into word 0
   localparam logic [15:0] ERR_NONE     = 16'h0000;
   localparam logic [15:0] ERR_CMD      = 16'h0e01;
   localparam logic [15:0] ERR_PARAM    = 16'h0e02;
   localparam logic [15:0] ERR_CONN     = 16'h0e03;
   localparam logic [15:0] ERR_ADDR     = 16'h0e04;
   localparam logic [15:0] ERR_SIG      = 16'h0e05;
   localparam logic [15:0] ERR_NOLINK   = 16'h0e06;
   localparam logic [15:0] ERR_TIMEOUT  = 16'h0e07;
   // ======================================================
   // Bus map and timing
   localparam logic [11:0] ADDR_DOORBELL = 12'h100;
   localparam logic [11:0] ADDR_STATUS   = 12'h104;
   localparam int          CLK_HZ        = 20000000;
   localparam int          SEC_S         = 1;
   localparam int          SEC_CYCLES    = CLK_HZ * SEC_S;
   localparam int          DSTR_MAX_CH   = 32;
   localparam logic [7:0]  CH_QUOTE      = 8'h22;
   localparam logic [7:0]  CH_WAIT_UP    = 8'h57;
   localparam logic [7:0]  CH_WAIT_LO    = 8'h77;
   localparam logic [7:0]  CH_PAUSE      = 8'h2c;
   typedef enum logic [2:0] {
      ST_IDLE, ST_DECODE, ST_RESET, ST_SEND, ST_WAIT, ST_FINISH
   } mcbi_state_t;
endpackage

/* src/mcbi_divider.sv */
// Programmable divider producing a one-cycle enable pulse
module mcbi_divider #(
   parameter int W = 25
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] div,
   output logic              tick
);
   logic [W-1:0] cnt_r;

   // ======================================================
   // Counter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
         tick  <= 1'b0;
      end else if (cnt_r + W'(1) >= div) begin
         cnt_r <= '0;
         tick  <= 1'b1;
      end else begin
         cnt_r <= cnt_r + W'(1);
         tick  <= 1'b0;
      end
   end
endmodule

/* src/mcbi_uart_tx.sv */
// Serial transmitter with selectable character format
module mcbi_uart_tx (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       baud_en,
   input  wire logic       start,
   input  wire logic [7:0] data,
   input  wire logic       eight_bits,
   input  wire logic [1:0] parity,
   input  wire logic       two_stop,
   output logic            txd,
   output logic            busy
);
   logic [11:0] frame;
   logic [11:0] shift_r;
   logic [3:0]  left_r;
   logic [3:0]  len;
   logic        par_bit;

   // ======================================================
   // Frame assembly
   always_comb begin
      frame   = 12'hfff;
      par_bit = eight_bits ? ^data : ^data[6:0];
      frame[0] = 1'b0;
      for (int i = 0; i < 7; i++) begin
         frame[1+i] = data[i];
      end
      if (eight_bits) begin
         frame[8] = data[7];
      end
      if (parity != 2'd0) begin // [RULE7]
         frame[eight_bits ? 9 : 8] = (parity == 2'd1) ? ~par_bit : par_bit;
      end
      len = 4'd9 + {3'd0, eight_bits} + {3'd0, parity != 2'd0} + {3'd0, two_stop};
   end

   // ======================================================
   // Shifter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shift_r <= 12'hfff;
         left_r  <= 4'd0;
         busy    <= 1'b0;
         txd     <= 1'b1;
      end else if (start && !busy) begin
         shift_r <= frame;
         left_r  <= len;
         busy    <= 1'b1;
      end else if (busy && baud_en) begin
         txd     <= shift_r[0];
         shift_r <= {1'b1, shift_r[11:1]};
         left_r  <= left_r - 4'd1;
         if (left_r == 4'd0) begin
            busy <= 1'b0;
            txd  <= 1'b1;
         end
      end
   end
endmodule

/* test/mcbi_properties.sv */
// Port checks for the command block interpreter
module mcbi_properties (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       modem_reset,
   input wire logic       modem_off_hook,
   input wire logic       modem_data_mode,
   input wire logic       handler_run,
   input wire logic [5:0] handler_sel,
   input wire logic [3:0] modem_txd,
   input wire logic [1:0] port_sel,
   input wire logic [1:0] flow_sel
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ==========================================
   // Modem and handler relations
   a_reset_pulse: assert property (modem_reset |=> !modem_reset)
      else $error("modem reset longer than one cycle");
   a_reset_hook: assert property (modem_reset |-> ##[0:1] modem_off_hook)
      else $error("modem reset outside a dial");
   a_handler_code: assert property (handler_run |->
      handler_sel inside {6'h20, 6'h24, 6'h26})
      else $error("bad handler code");
   a_flow_code: assert property (handler_run |-> flow_sel != 2'h3)
      else $error("bad flow code");
   a_port_only: assert property ((modem_txd | (4'h1 << port_sel)) == 4'hf)
      else $error("unselected port toggled");
   a_idle_lines: assert property (!handler_run |-> modem_txd == 4'hf)
      else $error("lines active without handler");
   a_data_hook: assert property (modem_data_mode |-> modem_off_hook)
      else $error("data mode while on hook");
   a_hook_open: assert property ($rose(modem_off_hook) |-> handler_run)
      else $error("off hook without connection");
endmodule
bind mcbi_top mcbi_properties i_mcbi_properties (.clk(clk), .rst(rst),
   .modem_reset(modem_reset), .modem_off_hook(modem_off_hook),
   .modem_data_mode(modem_data_mode), .handler_run(handler_run), .handler_sel(handler_sel),
   .modem_txd(modem_txd), .port_sel(port_sel), .flow_sel(flow_sel));

/* test/mcbi_modem_model.sv */
// Dial-up modem that reports dial completion after the first character
module mcbi_modem_model (
   input  wire logic clk,
   input  wire logic off_hook,
   input  wire logic txd,
   input  wire logic ok_en,
   output logic      done,
   output logic      ok
);
   timeunit 1ns;
   timeprecision 1ns;
   // After each done pulse ok shows the wrong level, so a stray sample is caught
   initial begin
      done = 1'b0;
      ok = 1'b1;
      forever begin
         @(posedge off_hook);
         @(negedge txd);
         repeat (22000) @(posedge clk);
         done <= 1'b1;
         ok <= ok_en;
         @(posedge clk);
         done <= 1'b0;
         ok <= ~ok_en;
      end
   end
endmodule

/* test/tb_top.sv */
// Bus-level test of the command block interpreter
module tb_top;
   import mcbi_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, hsel = 0, hwrite = 0, done, ok, ok_en = 1, hreadyout, hresp;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
   logic [1:0] htrans = 0, port_sel, flow_sel;
   logic [3:0] txd;
   logic [5:0] handler_sel;
   logic mr, oh, dm, aa, bo, to, handler_run;
   int n_errors = 0, cmp_count = 0;
   mcbi_top #(.SEC_CYC(100)) i_mcbi_top (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .modem_dial_done(done),
      .modem_dial_ok(ok), .modem_txd(txd), .modem_reset(mr), .modem_off_hook(oh),
      .modem_data_mode(dm), .modem_auto_answer(aa), .modem_busy_det_off(bo),
      .modem_tone_det_off(to), .handler_run(handler_run), .handler_sel(handler_sel),
      .port_sel(port_sel), .flow_sel(flow_sel));
   mcbi_modem_model i_mcbi_modem_model (.clk(clk), .off_hook(oh), .txd(txd[2]),
      .ok_en(ok_en), .done(done), .ok(ok));
   initial forever #25 clk = ~clk;
   // ==========================================
   // Bus, block and compare tasks
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 20'h0, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // Writes a block at word b, rings the doorbell and checks the error word
   task run(input int b, input logic [15:0] v [12], input logic [15:0] e);
      for (int i = 0; i < 12; i++) bus(1'b1, 12'(4 * (b + i)), {16'h0, v[i]});
      bus(1'b1, ADDR_DOORBELL, 32'(b));
      for (int i = 0; i < 40000; i++) begin
         bus(1'b0, ADDR_STATUS, 32'h0);
         if (q[0] === 1'b0) break;
      end
      bus(1'b0, 12'(4 * b), 32'h0);
      chk("error word", {16'h0, e}, q);
      $display("test at word %0d done", b);
   endtask
   task summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge clk);
      n_errors++;
      summarize;
   end
   // ==========================================
   // Test sequence
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      // Table at word 32 asks for auto answer; dial text at 48 is "1"
      for (int i = 0; i < 8; i++)
         bus(1'b1, 12'(128 + 4 * i), (i == 0) ? 32'h4154 : (i == 2) ? 32'h1 : 32'h0);
      bus(1'b1, 12'hc0, 32'h2231);
      bus(1'b1, 12'hc4, 32'h2200);
      run(0, '{0, 1, 19220, 36, 3, 9600, 7, 1, 1, 0, 1, 32}, ERR_CONN);
      run(0, '{0, 1, 19223, 36, 3, 9600, 7, 1, 1, 0, 1, 32}, ERR_NONE);
      chk("handler", 32'd36, 32'(handler_sel));
      chk("port", 32'd2, 32'(port_sel));
      run(16, '{0, 16'h401, 19224, 0, 48, 0, 0, 0, 0, 0, 0, 0}, ERR_CONN);
      run(16, '{0, 16'h401, 19223, 0, 0, 0, 0, 0, 0, 0, 0, 0}, ERR_ADDR);
      run(16, '{0, 16'h401, 19223, 0, 48, 1, 0, 0, 0, 0, 0, 0}, ERR_NONE);
      chk("modem state", 32'h7, {27'h0, hresp, to, oh, bo, dm});
      run(16, '{0, 16'h402, 19223, 0, 0, 0, 0, 0, 0, 0, 0, 0}, ERR_NONE);
      chk("hang up state", 32'h1, {30'h0, oh, aa});
      run(16, '{0, 16'h402, 19223, 0, 0, 0, 0, 0, 0, 0, 0, 0}, ERR_NONE);
      ok_en <= 1'b0;
      run(16, '{0, 16'h401, 19223, 1, 48, 0, 1, 1, 0, 0, 0, 0}, ERR_NOLINK);
      run(16, '{0, 16'h402, 19223, 0, 0, 0, 0, 0, 0, 0, 0, 0}, ERR_NONE);
      summarize;
   end
endmodule
